// >>> rtl/bit_unpacker.sv
// One-byte shift register that hands out body bits, most significant first.
// Assumes the caller loads only when empty and shifts only when not empty.
module bit_unpacker
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic load,
    input wire logic [7:0] load_byte,
    input wire logic shift,
    output logic bit_out,
    output logic empty
);

    raster_pkg::unpack_state_t s;
    raster_pkg::unpack_state_t next_s;

    assign bit_out = s.shreg[7];
    assign empty = (s.left == 4'h0);

    always_comb
    begin
        next_s = s;
        if (flush)
        begin
            next_s.left = 4'h0;
        end
        else if (load)
        begin
            next_s.shreg = load_byte;
            next_s.left = raster_pkg::BITS_PER_BYTE;
        end
        else if (shift)
        begin
            next_s.shreg = {s.shreg[6:0], 1'b1};
            next_s.left = 4'(s.left - 4'h1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule // bit_unpacker

// >>> rtl/raster_image_decoder.sv
// Raster image decoder: reads an image instance from a byte file store and
// streams its points, in monochrome or colour look-up form, to a consumer.
// Assumes the store answers each held read with one mem_ack cycle.
//
// Notes on behaviour
// - Points leave in raster order, numbered from 1 at upper left.
// - Monochrome header: width byte, height byte, body from third byte.
// - Monochrome point is one body bit; one means set, no colour.
// - Padding ones after the last point in the final byte are ignored.
// - Colour header: width, height, bits per point, count, table location.
// - Bits per point is a binary index width, legal from 1 to 8.
// - Entry count zero means 256; count must not exceed two to the width.
// - Table entries indexed from zero; each index picks exactly one entry.
// - Table location is 16 bits, first byte high, second byte low.
// - Colour indices packed contiguously, most significant bit first.
// - Each entry is three bytes red, green, blue at three times index.
// - Colour bytes are intensities passed straight through, FF is maximum.
// - Table is read by location only, so images may share one table.
module raster_image_decoder
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic start_colour,
    input wire logic [15:0] image_base,
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic pix_valid,
    input wire logic pix_ready,
    output raster_pkg::pixel_t pix,
    output logic frame_done,
    output logic format_error,
    output logic busy
);

    raster_pkg::dec_state_t s;
    raster_pkg::dec_state_t next_s;
    logic unpack_flush;
    logic unpack_load;
    logic unpack_shift;
    logic unpack_bit;
    logic unpack_empty;
    logic took;
    logic [7:0] next_idx;
    logic [9:0] limit;

    ////////////////////////////////////////////////////////////////////////////////

    bit_unpacker body_bits
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(unpack_flush),
        .load(unpack_load),
        .load_byte(mem_rdata),
        .shift(unpack_shift),
        .bit_out(unpack_bit),
        .empty(unpack_empty)
    );

    assign mem_rd = s.mem_rd;
    assign mem_addr = s.addr;
    assign pix = s.pix;
    assign pix_valid = (s.phase == raster_pkg::ST_EMIT);
    assign frame_done = s.frame_done;
    assign format_error = s.format_error;
    assign busy = (s.phase != raster_pkg::ST_IDLE) && (s.phase != raster_pkg::ST_ERROR);
    assign took = s.mem_rd && mem_ack;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        next_s = s;
        next_s.frame_done = 1'b0;
        unpack_flush = 1'b0;
        unpack_load = 1'b0;
        unpack_shift = 1'b0;
        next_idx = {s.idx[6:0], unpack_bit};
        limit = 10'(10'h001 << s.bpp[3:0]);
        if (took)
        begin
            next_s.mem_rd = 1'b0;
        end
        case (s.phase)
            raster_pkg::ST_IDLE, raster_pkg::ST_ERROR:
            begin
                if (start)
                begin
                    next_s.phase = raster_pkg::ST_HEADER;
                    next_s.colour = start_colour;
                    next_s.hdr_idx = 3'h0;
                    next_s.addr = image_base;
                    next_s.bpp = raster_pkg::MONO_BPP;
                    next_s.count = raster_pkg::MONO_COUNT;
                    next_s.mem_rd = 1'b1;
                    next_s.format_error = 1'b0;
                    unpack_flush = 1'b1;
                end
            end
            raster_pkg::ST_HEADER:
            begin
                if (took)
                begin
                    case (s.hdr_idx)
                        raster_pkg::OFS_WIDTH: next_s.width = mem_rdata;
                        raster_pkg::OFS_HEIGHT: next_s.height = mem_rdata;
                        raster_pkg::OFS_BPP: next_s.bpp = mem_rdata;
                        raster_pkg::OFS_COUNT:
                        begin
                            next_s.count = (mem_rdata == 8'h00) ? raster_pkg::COUNT_OF_ZERO
                                : {1'b0, mem_rdata};
                        end
                        raster_pkg::OFS_LOC_HIGH: next_s.loc[15:8] = mem_rdata;
                        raster_pkg::OFS_LOC_LOW: next_s.loc[7:0] = mem_rdata;
                        default: next_s.loc = s.loc;
                    endcase
                    next_s.addr = 16'(s.addr + 16'h0001);
                    next_s.hdr_idx = 3'(s.hdr_idx + 3'h1);
                    if (s.hdr_idx == (s.colour ? raster_pkg::COLOUR_HDR_LAST
                        : raster_pkg::MONO_HDR_LAST))
                    begin
                        next_s.phase = raster_pkg::ST_CHECK;
                        next_s.body = 16'(s.addr + 16'h0001);
                    end
                    else
                    begin
                        next_s.mem_rd = 1'b1;
                    end
                end
            end
            raster_pkg::ST_CHECK:
            begin
                next_s.row = 8'h00;
                next_s.col = 8'h00;
                next_s.number = raster_pkg::FIRST_POINT;
                next_s.got = 4'h0;
                next_s.idx = 8'h00;
                if (s.colour && ((s.bpp < raster_pkg::MIN_BPP) || (s.bpp > raster_pkg::MAX_BPP)))
                begin
                    next_s.phase = raster_pkg::ST_ERROR;
                    next_s.format_error = 1'b1;
                end
                else if (s.colour && ({1'b0, s.count} > limit))
                begin
                    next_s.phase = raster_pkg::ST_ERROR;
                    next_s.format_error = 1'b1;
                end
                else if ((s.width == 8'h00) || (s.height == 8'h00))
                begin
                    next_s.phase = raster_pkg::ST_IDLE;
                    next_s.frame_done = 1'b1;
                end
                else
                begin
                    next_s.phase = raster_pkg::ST_BITS;
                end
            end
            raster_pkg::ST_FETCH:
            begin
                if (took)
                begin
                    unpack_load = 1'b1;
                    next_s.body = 16'(s.body + 16'h0001);
                    next_s.phase = raster_pkg::ST_BITS;
                end
            end
            raster_pkg::ST_BITS:
            begin
                if (unpack_empty)
                begin
                    // Rows share bytes, so only the frame start realigns to a byte.
                    next_s.phase = raster_pkg::ST_FETCH;
                    next_s.addr = s.body;
                    next_s.mem_rd = 1'b1;
                end
                else
                begin
                    unpack_shift = 1'b1;
                    next_s.idx = next_idx;
                    next_s.got = 4'(s.got + 4'h1);
                    if (4'(s.got + 4'h1) == s.bpp[3:0])
                    begin
                        next_s.pix.number = s.number;
                        next_s.pix.row = s.row;
                        next_s.pix.col = s.col;
                        next_s.pix.index = next_idx;
                        next_s.pix.red = 8'h00;
                        next_s.pix.green = 8'h00;
                        next_s.pix.blue = 8'h00;
                        if (!s.colour)
                        begin
                            next_s.pix.set = unpack_bit;
                            next_s.phase = raster_pkg::ST_EMIT;
                        end
                        else if ({1'b0, next_idx} >= s.count)
                        begin
                            next_s.phase = raster_pkg::ST_ERROR;
                            next_s.format_error = 1'b1;
                        end
                        else
                        begin
                            next_s.pix.set = 1'b0;
                            next_s.addr = 16'(s.loc + {7'h00, next_idx, 1'b0}
                                + {8'h00, next_idx});
                            next_s.sel = raster_pkg::SEL_RED;
                            next_s.mem_rd = 1'b1;
                            next_s.phase = raster_pkg::ST_TABLE;
                        end
                    end
                end
            end
            raster_pkg::ST_TABLE:
            begin
                if (took)
                begin
                    case (s.sel)
                        raster_pkg::SEL_RED: next_s.pix.red = mem_rdata;
                        raster_pkg::SEL_GREEN: next_s.pix.green = mem_rdata;
                        default: next_s.pix.blue = mem_rdata;
                    endcase
                    if (s.sel == raster_pkg::SEL_BLUE)
                    begin
                        next_s.phase = raster_pkg::ST_EMIT;
                    end
                    else
                    begin
                        next_s.sel = 2'(s.sel + 2'h1);
                        next_s.addr = 16'(s.addr + 16'h0001);
                        next_s.mem_rd = 1'b1;
                    end
                end
            end
            raster_pkg::ST_EMIT:
            begin
                if (pix_ready)
                begin
                    next_s.got = 4'h0;
                    next_s.idx = 8'h00;
                    next_s.number = 16'(s.number + 16'h0001);
                    next_s.phase = raster_pkg::ST_BITS;
                    if (s.col == 8'(s.width - 8'h01))
                    begin
                        next_s.col = 8'h00;
                        next_s.row = 8'(s.row + 8'h01);
                        if (s.row == 8'(s.height - 8'h01))
                        begin
                            // Leftover bits of the last byte are padding and are dropped.
                            next_s.phase = raster_pkg::ST_IDLE;
                            next_s.frame_done = 1'b1;
                        end
                    end
                    else
                    begin
                        next_s.col = 8'(s.col + 8'h01);
                    end
                end
            end
            default:
            begin
                next_s.phase = raster_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.phase <= raster_pkg::ST_IDLE;
            s.addr <= raster_pkg::RESET_ADDR;
            s.bpp <= raster_pkg::MONO_BPP;
            s.width <= raster_pkg::RESET_BYTE;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule // raster_image_decoder

// >>> rtl/raster_pkg.sv
// Shared constants and types for the raster image decoder.
// Assumes a byte-wide file store whose reads are acknowledged after any latency.
package raster_pkg;

    // Header layout, as byte offsets from the start of an image instance.
    localparam logic [2:0] OFS_WIDTH = 3'h0;
    localparam logic [2:0] OFS_HEIGHT = 3'h1;
    localparam logic [2:0] OFS_BPP = 3'h2;
    localparam logic [2:0] OFS_COUNT = 3'h3;
    localparam logic [2:0] OFS_LOC_HIGH = 3'h4;
    localparam logic [2:0] OFS_LOC_LOW = 3'h5;
    localparam logic [2:0] MONO_HDR_LAST = 3'h1;
    localparam logic [2:0] COLOUR_HDR_LAST = 3'h5;

    localparam logic [7:0] MONO_BPP = 8'h01;
    localparam logic [7:0] MIN_BPP = 8'h01;
    localparam logic [7:0] MAX_BPP = 8'h08;
    localparam logic [8:0] COUNT_OF_ZERO = 9'h100;
    localparam logic [8:0] MONO_COUNT = 9'h002;
    localparam logic [1:0] SEL_RED = 2'h0;
    localparam logic [1:0] SEL_GREEN = 2'h1;
    localparam logic [1:0] SEL_BLUE = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [15:0] FIRST_POINT = 16'h0001;

    // Reset values.
    localparam logic [15:0] RESET_ADDR = 16'h0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HEADER,
        ST_CHECK,
        ST_FETCH,
        ST_BITS,
        ST_TABLE,
        ST_EMIT,
        ST_ERROR
    } dec_phase_t;

    typedef struct packed {
        logic [15:0] number;
        logic [7:0] row;
        logic [7:0] col;
        logic set;
        logic [7:0] index;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pixel_t;

    typedef struct packed {
        dec_phase_t phase;
        logic colour;
        logic [2:0] hdr_idx;
        logic [15:0] addr;
        logic [15:0] body;
        logic [7:0] width;
        logic [7:0] height;
        logic [7:0] bpp;
        logic [8:0] count;
        logic [15:0] loc;
        logic [7:0] idx;
        logic [3:0] got;
        logic [7:0] row;
        logic [7:0] col;
        logic [15:0] number;
        logic [1:0] sel;
        pixel_t pix;
        logic mem_rd;
        logic frame_done;
        logic format_error;
    } dec_state_t;

    typedef struct packed {
        logic [7:0] shreg;
        logic [3:0] left;
    } unpack_state_t;

endpackage

// >>> testbench/file_store_model.sv
// File store model: one byte array answering held reads, at once or after a wait.
// Assumes the decoder holds mem_rd and mem_addr until mem_ack.
module file_store_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Images and tables share one array, as they share one file.
    logic [7:0] mem [0:65535];
    logic waited;
    initial
        for (int a = 0; a < 65536; a++)
            mem[a] = 8'(a) ^ 8'ha5;
    assign mem_ack = mem_rd && (!slow || waited);
    // Off the ack cycle the byte is inverted, so a late sample cannot pass.
    assign mem_rdata = mem_ack ? mem[mem_addr] : ~mem[mem_addr];
    always_ff @(posedge sys_clk or posedge rst)
        if (rst)
            waited <= 1'b0;
        else
            waited <= mem_rd && !mem_ack;
endmodule // file_store_model

// >>> testbench/raster_image_decoder_bench.sv
// Testbench for the raster image decoder: both schemes, a shared table, bad headers.
// Assumes the file store model on the memory port and the bound checker.
module raster_image_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic start_colour = 1'b0;
    logic [15:0] image_base = 16'h0000;
    logic pix_ready = 1'b0;
    logic slow = 1'b0;
    logic mem_rd, mem_ack, pix_valid, frame_done, format_error, busy;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata;
    raster_pkg::pixel_t pix;
    logic [15:0][7:0] idx;
    int n_errors = 0;
    int samples_checked = 0;
    always #10 sys_clk = ~sys_clk;
    raster_image_decoder uut (.sys_clk(sys_clk), .rst(rst), .start(start),
        .start_colour(start_colour), .image_base(image_base), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix(pix), .frame_done(frame_done),
        .format_error(format_error), .busy(busy));
    file_store_model store (.sys_clk(sys_clk), .rst(rst), .slow(slow), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    task automatic check(input logic [64:0] seen, exp, input string what);
        samples_checked++;
        n_errors += int'(seen !== exp);
        if (seen !== exp)
            $display("wrong value %s expected %h seen %h", what, exp, seen);
    endtask
    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Starts off the edge, so the edge's own updates have landed.
    task automatic wait_for(input logic err);
        @(negedge sys_clk);
        for (int t = 0; t < 400 && (err ? format_error : pix_valid) !== 1'b1; t++)
            @(negedge sys_clk);
        check(err ? format_error : pix_valid, 1'b1, "wait");
    endtask
    task automatic run(input logic col, bad, input logic [15:0] base, loc,
                       input logic [7:0] w, h, b, c);
        raster_pkg::pixel_t e;
        logic [127:0] bits;
        logic [47:0] hd;
        logic [15:0] t;
        int n;
        n = bad ? 0 : w * h;
        bits = '1;
        hd = {w, h, b, c, loc};
        for (int j = 0; j < 6; j++)
            store.mem[base + 16'(j)] = hd[47 - 8 * j -: 8];
        for (int p = 0; p < n; p++)
            for (int i = 0; i < b; i++)
                bits[128 - b * (p + 1) + i] = idx[p][i];
        t = base + (col ? 16'h0006 : 16'h0002);
        for (int j = 0; j < 16; j++)
            store.mem[t + 16'(j)] = bits[127 - 8 * j -: 8];
        @(posedge sys_clk);
        start <= 1'b1;
        start_colour <= col;
        image_base <= base;
        @(posedge sys_clk);
        start <= 1'b0;
        for (int p = 0; p < n; p++)
        begin
            wait_for(1'b0);
            e = '0;
            e.number = 16'(p + 1);
            e.row = 8'(p / w);
            e.col = 8'(p % w);
            e.index = idx[p];
            e.set = !col && idx[p][0];
            t = loc + 16'(3 * idx[p]);
            if (col)
                {e.red, e.green, e.blue} = {store.mem[t], store.mem[t + 16'h0001],
                    store.mem[t + 16'h0002]};
            check(pix, e, "pix");
            @(posedge sys_clk);
            pix_ready <= 1'b1;
            @(posedge sys_clk);
            pix_ready <= 1'b0;
        end
        if (bad)
            wait_for(1'b1);
        else
            @(negedge sys_clk);
        check(frame_done, !bad, "frame_done");
        check(busy, 1'b0, "busy");
        check(format_error, bad, "format_error");
    endtask
    task automatic mono_image();
        idx = 128'h0000_0000_0000_0001_0001_0000_0101_0001;
        run(1'b0, 1'b0, 16'h0010, 16'h0000, 8'h03, 8'h03, 8'h01, 8'h00);
    endtask
    task automatic bad_headers();
        // The last header is legal, but the all-ones body gives index 3 against a count of 3.
        logic [15:0] hdr [5] = '{16'h0001, 16'h0901, 16'h0205, 16'h0100, 16'h0203};
        for (int i = 0; i < 5; i++)
            run(1'b1, 1'b1, 16'h0600, 16'h0400, 8'h02, 8'h01, hdr[i][15:8], hdr[i][7:0]);
    endtask
    task automatic colour_image();
        idx = 128'h0402_0103_0004;
        run(1'b1, 1'b0, 16'h0100, 16'h0400, 8'h03, 8'h02, 8'h03, 8'h05);
    endtask
    task automatic shared_table();
        idx = 128'h0302;
        slow <= 1'b1;
        run(1'b1, 1'b0, 16'h0200, 16'h0400, 8'h02, 8'h01, 8'h03, 8'h05);
        slow <= 1'b0;
    endtask
    task automatic full_count();
        idx = 128'h00ff;
        run(1'b1, 1'b0, 16'h0300, 16'h0500, 8'h02, 8'h01, 8'h08, 8'h00);
    endtask
    // A zero-width image ends right after its two header reads, with no point offered.
    task automatic empty_image();
        store.mem[16'h0700] = 8'h00;
        store.mem[16'h0701] = 8'h02;
        @(posedge sys_clk);
        start <= 1'b1;
        start_colour <= 1'b0;
        image_base <= 16'h0700;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check(frame_done, 1'b1, "empty frame_done");
        check(pix_valid, 1'b0, "empty pix_valid");
        check(busy, 1'b0, "empty busy");
    endtask
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        mono_image();
        bad_headers();
        colour_image();
        shared_table();
        full_count();
        empty_image();
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end
endmodule // raster_image_decoder_bench

// >>> testbench/raster_image_decoder_chk.sv
// Port checker for the raster image decoder, bound to every decoder.
// Assumes one clock domain with an asynchronous active-high reset.
module raster_image_decoder_chk
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic start_colour,
    input wire logic [15:0] image_base,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire raster_pkg::pixel_t pix,
    input wire logic frame_done,
    input wire logic format_error,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    chk_read_holds: assert property (mem_rd && !mem_ack
        |=> mem_rd && $stable(mem_addr)) else $error("read moved early");
    chk_header_first: assert property (start && !busy
        |=> busy && mem_rd && mem_addr == $past(image_base)) else $error("bad first read");
    chk_pix_holds: assert property (pix_valid && !pix_ready
        |=> pix_valid && $stable(pix)) else $error("point changed in stall");
    chk_first_point: assert property (pix_valid && pix.number == raster_pkg::FIRST_POINT
        |-> pix.row == 8'h00 && pix.col == 8'h00) else $error("first point misplaced");
    chk_take_gap: assert property (pix_valid && pix_ready |=> !pix_valid)
        else $error("point offered twice");
    chk_error_quiet: assert property (format_error |-> !pix_valid && !frame_done && !busy)
        else $error("output after error");
    chk_error_clears: assert property (start && !busy |=> !format_error)
        else $error("error kept");
    chk_done_idle: assert property (frame_done |-> !busy && !pix_valid ##1 !frame_done)
        else $error("bad frame done");
    cover property (pix_valid && pix_ready);
    cover property ($rose(format_error));
    cover property (frame_done);
endmodule // raster_image_decoder_chk

bind raster_image_decoder raster_image_decoder_chk chk_i (.sys_clk(sys_clk), .rst(rst),
    .start(start), .start_colour(start_colour), .image_base(image_base), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix(pix), .frame_done(frame_done), .format_error(format_error),
    .busy(busy));
